// file: logic/io_master.v
// I/O master: backplane instruction decode, interrupt chain, chained DMA.
// Assumes backplane signals are synchronous to clk; user pins are not.
//
// Notes on behaviour
// - Own select code comes only from the switches, never slot position.
// - Preaddressed card is selected; select bits then address card functions.
// - Preaddressing off: instruction select bits decide if user circuit addressed.
// - Interrupt priority follows chain position; nearer processor wins.
// - Mask register blocks chosen interfaces; cleared bits stay free to interrupt.
// - DMA moves whole block silently; one interrupt at block end.
// - Chained mode: no interrupt at block end; fetch next set, restart.
// - Chaining repeats while further control word sets remain.
// - Byte mode packs bytes into words on input, unpacks on output.
// - DMA sustains up to 700,000 words per second.
// - Card decodes I/O instructions and gives user ready-made strobes.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "io_master_map.vh"

module io_master (
  input wire clk, // 40 MHz clock
  input wire nrst, // Synchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  output reg irq, // Local interrupt, level
  input wire [5:0] sc_switch, // Select code switches (pins)
  input wire ioi_valid, // Backplane I/O instruction strobe
  input wire [5:0] ioi_sc, // Instruction select code bits
  input wire [3:0] ioi_fn, // Instruction function
  input wire [15:0] ioi_wdata, // Instruction data to card
  output reg ioi_ack, // Instruction accepted pulse
  output reg [15:0] ioi_rdata, // Instruction data from card
  input wire pri_in, // Priority chain in, high when free
  output reg pri_out, // Priority chain out to farther cards
  output reg bp_irq, // Backplane interrupt request
  output reg mem_req, // Memory cycle request
  output reg mem_we, // Memory cycle is a write
  output reg [15:0] mem_addr, // Memory word address
  output reg [15:0] mem_wdata, // Memory write data
  input wire mem_gnt, // Memory cycle done pulse
  input wire [15:0] mem_rdata, // Memory read data, valid with grant
  input wire user_dreq, // User item ready (pin level)
  input wire user_attn, // User attention request (pin level)
  input wire [15:0] user_rdata, // User data to card (pins)
  output reg [5:0] user_addr, // Function address to user
  output reg [15:0] user_wdata, // Data to user
  output reg user_wr, // Write strobe to user
  output reg user_rd, // Read strobe to user
  output reg user_ctl, // Control strobe to user
  output reg user_dack // DMA item taken from user
);

  localparam S_IDLE = 3'h0;
  localparam S_FETCH = 3'h1;
  localparam S_BEGIN = 3'h2;
  localparam S_WAIT = 3'h3;
  localparam S_MRD = 3'h4;
  localparam S_MWR = 3'h5;
  localparam S_END = 3'h6;
  // Full-width copy first so the pacing count is narrowed on purpose
  localparam [31:0] ITEM_CYC_W = `DMA_ITEM_CYC;
  localparam [6:0] ITEM_CYC = ITEM_CYC_W[6:0];

  wire [5:0] sc_s;
  wire dreq_s;
  wire attn_s;
  wire [15:0] urd_s;
  reg dreq_d1_q;
  reg attn_d1_q;
  reg [4:0] ctrl_q;
  reg [5:0] preaddr_q;
  reg [15:0] reg_addr_q;
  reg [15:0] reg_count_q;
  reg [15:0] reg_ptr_q;
  reg [`IRQ_W-1:0] stat_q;
  reg [`IRQ_W-1:0] en_q;
  reg [15:0] mask_q;
  reg [2:0] state_q;
  reg [15:0] addr_q;
  reg [15:0] cnt_q;
  reg [15:0] ptr_q;
  reg [15:0] pack_q;
  reg byte_q;
  reg dir_q;
  reg more_q;
  reg bsel_q;
  reg [1:0] fidx_q;
  reg [6:0] pace_q;
  reg [`IRQ_W-1:0] ev_d;
  reg [31:0] rd_d;
  reg map_d;

  // Switches and user pins cross into the clock domain here
  sync2 #(.W(24)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({sc_switch, user_dreq, user_attn, user_rdata}),
    .q({sc_s, dreq_s, attn_s, urd_s})
  );

  wire dreq_rise = dreq_s & ~dreq_d1_q;
  wire attn_rise = attn_s & ~attn_d1_q;
  wire apb_acc = psel & penable & pready;
  wire busy = (state_q != S_IDLE);
  wire pre_on = ctrl_q[`CTRL_PREADDR_ON];
  // Address only ever compared against the switches, not slot wiring
  wire card_hit = pre_on ? (preaddr_q == sc_s)
                         : (ioi_sc == sc_s);
  wire global_fn = (ioi_fn == `FN_MASK) || (ioi_fn == `FN_PREADDR) ||
                   (ioi_fn == `FN_PREADDR_OFF);
  wire ioi_take = ioi_valid & (card_hit | global_fn);
  wire pace_ok = (pace_q == 7'h00);
  wire item_go = (state_q == S_WAIT) & dreq_rise & pace_ok;
  wire own_masked = mask_q[sc_s[3:0]];
  wire irq_pend = |(stat_q & en_q);

  // APB read mux and decode of mapped offsets
  always @* begin
    rd_d = 32'h00000000;
    map_d = 1'b1;
    case (paddr)
      `REG_CTRL: rd_d = {27'h0000000, ctrl_q};
      `REG_PREADDR: rd_d = {26'h0000000, preaddr_q};
      `REG_DMA_ADDR: rd_d = {16'h0000, reg_addr_q};
      `REG_DMA_COUNT: rd_d = {16'h0000, reg_count_q};
      `REG_CHAIN_PTR: rd_d = {16'h0000, reg_ptr_q};
      `REG_IRQ_STAT: rd_d = {29'h00000000, stat_q};
      `REG_IRQ_CLR: rd_d = 32'h00000000;
      `REG_IRQ_EN: rd_d = {29'h00000000, en_q};
      `REG_MASK: rd_d = {16'h0000, mask_q};
      `REG_STATE: rd_d = {cnt_q, 11'h000,
                          card_hit, bsel_q, state_q};
      default: map_d = 1'b0;
    endcase
  end

  // Zero-wait slave: ready in the access cycle, data captured in setup
  always @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_d;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h00000000 : rd_d;
      end
    end
  end

  // Events that set sticky status bits
  always @* begin
    ev_d = {`IRQ_W{1'b0}};
    ev_d[`IRQ_USER_ATTN] = attn_rise;
    if (state_q == S_END && !(ctrl_q[`CTRL_CHAIN] && more_q)) begin
      if (ctrl_q[`CTRL_CHAIN]) begin
        ev_d[`IRQ_CHAIN_DONE] = 1'b1;
      end else begin
        ev_d[`IRQ_BLOCK_DONE] = 1'b1;
      end
    end
  end

  // Software registers; a new event wins over a same-cycle clear
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= `CTRL_RESET;
      preaddr_q <= 6'h00;
      reg_addr_q <= 16'h0000;
      reg_count_q <= 16'h0000;
      reg_ptr_q <= 16'h0000;
      en_q <= {`IRQ_W{1'b0}};
      stat_q <= {`IRQ_W{1'b0}};
      mask_q <= 16'h0000;
    end else begin
      if (apb_acc && pwrite && paddr == `REG_CTRL) begin
        ctrl_q <= {pwdata[4:1], 1'b0}; // Go bit never stored
      end
      if (apb_acc && pwrite && paddr == `REG_DMA_ADDR) begin
        reg_addr_q <= pwdata[15:0];
      end
      if (apb_acc && pwrite && paddr == `REG_DMA_COUNT) begin
        reg_count_q <= pwdata[15:0];
      end
      if (apb_acc && pwrite && paddr == `REG_CHAIN_PTR) begin
        reg_ptr_q <= pwdata[15:0];
      end
      if (apb_acc && pwrite && paddr == `REG_IRQ_EN) begin
        en_q <= pwdata[`IRQ_W-1:0];
      end
      if (apb_acc && pwrite && paddr == `REG_IRQ_CLR) begin
        stat_q <= (stat_q & ~pwdata[`IRQ_W-1:0]) | ev_d;
      end else begin
        stat_q <= stat_q | ev_d;
      end
      // Preaddress register loaded by software over either path
      if (apb_acc && pwrite && paddr == `REG_PREADDR) begin
        preaddr_q <= pwdata[5:0];
      end else if (ioi_valid && ioi_fn == `FN_PREADDR) begin
        preaddr_q <= ioi_wdata[5:0];
      end
      if (ioi_valid && ioi_fn == `FN_PREADDR_OFF) begin
        ctrl_q[`CTRL_PREADDR_ON] <= 1'b0;
      end else if (ioi_valid && ioi_fn == `FN_PREADDR) begin
        ctrl_q[`CTRL_PREADDR_ON] <= 1'b1;
      end
      // Mask word is broadcast to every card; bit set blocks that card
      if (apb_acc && pwrite && paddr == `REG_MASK) begin
        mask_q <= pwdata[15:0];
      end else if (ioi_valid && ioi_fn == `FN_MASK) begin
        mask_q <= ioi_wdata;
      end
    end
  end

  // Instruction execution turned into user strobes
  always @(posedge clk) begin
    if (!nrst) begin
      ioi_ack <= 1'b0;
      ioi_rdata <= 16'h0000;
      user_addr <= 6'h00;
      user_rd <= 1'b0;
      user_ctl <= 1'b0;
    end else begin
      ioi_ack <= ioi_take;
      user_rd <= 1'b0;
      user_ctl <= 1'b0;
      if (ioi_take && !global_fn) begin
        // Preaddressed: select bits name a function on the card
        user_addr <= pre_on ? ioi_sc : 6'h00;
        case (ioi_fn)
          `FN_READ: begin
            ioi_rdata <= urd_s;
            user_rd <= 1'b1;
          end
          `FN_CONTROL: begin
            user_ctl <= 1'b1;
          end
          `FN_STATUS: begin
            ioi_rdata <= {13'h0000, stat_q};
          end
          default: begin
            ioi_rdata <= ioi_rdata;
          end
        endcase
      end
    end
  end

  // Priority chain: a pending unmasked request here blocks all farther cards
  always @(posedge clk) begin
    if (!nrst) begin
      pri_out <= 1'b0;
      bp_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      pri_out <= pri_in & ~(irq_pend & ~own_masked);
      bp_irq <= pri_in & irq_pend & ~own_masked;
      irq <= irq_pend;
    end
  end

  // DMA engine; data path, user_wr and user_dack share one process
  always @(posedge clk) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      addr_q <= 16'h0000;
      cnt_q <= 16'h0000;
      ptr_q <= 16'h0000;
      pack_q <= 16'h0000;
      byte_q <= 1'b0;
      dir_q <= 1'b0;
      more_q <= 1'b0;
      bsel_q <= 1'b0;
      fidx_q <= 2'h0;
      pace_q <= 7'h00;
      dreq_d1_q <= 1'b0;
      attn_d1_q <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      user_wdata <= 16'h0000;
      user_wr <= 1'b0;
      user_dack <= 1'b0;
    end else begin
      dreq_d1_q <= dreq_s;
      attn_d1_q <= attn_s;
      user_wr <= 1'b0;
      user_dack <= 1'b0;
      if (ioi_take && ioi_fn == `FN_WRITE) begin
        user_wdata <= ioi_wdata;
        user_wr <= 1'b1;
      end
      // Spacing of one item per 57 clocks keeps above 700k words/s
      if (item_go) begin
        pace_q <= ITEM_CYC - 7'h01;
      end else if (!pace_ok) begin
        pace_q <= pace_q - 7'h01;
      end
      case (state_q)
        S_IDLE: begin
          bsel_q <= 1'b0;
          if (apb_acc && pwrite && paddr == `REG_CTRL &&
              pwdata[`CTRL_GO]) begin
            if (pwdata[`CTRL_CHAIN]) begin
              ptr_q <= reg_ptr_q;
              fidx_q <= 2'h0;
              state_q <= S_FETCH;
            end else begin
              addr_q <= reg_addr_q;
              cnt_q <= reg_count_q;
              byte_q <= pwdata[`CTRL_BYTE];
              dir_q <= pwdata[`CTRL_DIR_OUT];
              more_q <= 1'b0;
              state_q <= S_BEGIN;
            end
          end
        end
        S_FETCH: begin
          // Three control words: address, count, flags
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= ptr_q;
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            ptr_q <= ptr_q + 16'h0001;
            fidx_q <= fidx_q + 2'h1;
            case (fidx_q)
              2'h0: addr_q <= mem_rdata;
              2'h1: cnt_q <= mem_rdata;
              default: begin
                byte_q <= mem_rdata[`CW_BYTE];
                dir_q <= mem_rdata[`CW_DIR_OUT];
                more_q <= mem_rdata[`CW_MORE];
              end
            endcase
            if (fidx_q == `CW_COUNT - 2'h1) begin
              state_q <= S_BEGIN;
            end
          end
        end
        S_BEGIN: begin
          bsel_q <= 1'b0;
          if (cnt_q == 16'h0000) begin
            state_q <= S_END;
          end else if (dir_q) begin
            state_q <= S_MRD;
          end else begin
            state_q <= S_WAIT;
          end
        end
        S_MRD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= addr_q;
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            pack_q <= mem_rdata;
            addr_q <= addr_q + 16'h0001;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // No interrupt per item, only strobes to the user side
          if (item_go) begin
            cnt_q <= cnt_q - 16'h0001;
            if (dir_q) begin
              user_wr <= 1'b1;
              if (byte_q) begin
                user_wdata <= {8'h00, bsel_q ? pack_q[15:8]
                                             : pack_q[7:0]};
              end else begin
                user_wdata <= pack_q;
              end
              if (cnt_q == 16'h0001) begin
                state_q <= S_END;
              end else if (byte_q && !bsel_q) begin
                bsel_q <= 1'b1;
              end else begin
                bsel_q <= 1'b0;
                state_q <= S_MRD;
              end
            end else begin
              user_dack <= 1'b1;
              if (!byte_q) begin
                pack_q <= urd_s;
                state_q <= S_MWR;
              end else if (!bsel_q) begin
                // Odd final byte goes out with a zero high byte
                pack_q <= {8'h00, urd_s[7:0]};
                bsel_q <= 1'b1;
                if (cnt_q == 16'h0001) begin
                  state_q <= S_MWR;
                end
              end else begin
                pack_q[15:8] <= urd_s[7:0];
                state_q <= S_MWR;
              end
            end
          end
        end
        S_MWR: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= addr_q;
            mem_wdata <= pack_q;
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            bsel_q <= 1'b0;
            addr_q <= addr_q + 16'h0001;
            state_q <= (cnt_q == 16'h0000) ? S_END : S_WAIT;
          end
        end
        S_END: begin
          // Chained block end fetches the next set instead of interrupting
          if (ctrl_q[`CTRL_CHAIN] && more_q) begin
            fidx_q <= 2'h0;
            state_q <= S_FETCH;
          end else begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: logic/io_master_map.vh
// Offsets, fields, function codes and timing counts of the I/O master.
// Included by the I/O master design files; definitions only.
`ifndef IO_MASTER_MAP_VH
`define IO_MASTER_MAP_VH

// APB register byte offsets
`define REG_CTRL 8'h00
`define REG_PREADDR 8'h04
`define REG_DMA_ADDR 8'h08
`define REG_DMA_COUNT 8'h0C
`define REG_CHAIN_PTR 8'h10
`define REG_IRQ_STAT 8'h14
`define REG_IRQ_CLR 8'h18
`define REG_IRQ_EN 8'h1C
`define REG_MASK 8'h20
`define REG_STATE 8'h24

// Control register fields
`define CTRL_GO 0
`define CTRL_CHAIN 1
`define CTRL_BYTE 2
`define CTRL_DIR_OUT 3
`define CTRL_PREADDR_ON 4
`define CTRL_RESET 5'h00

// Third control word of a chained set
`define CW_BYTE 0
`define CW_DIR_OUT 1
`define CW_MORE 2

// Interrupt status bits
`define IRQ_BLOCK_DONE 0
`define IRQ_CHAIN_DONE 1
`define IRQ_USER_ATTN 2
`define IRQ_W 3

// I/O instruction function codes
`define FN_WRITE 4'h0
`define FN_READ 4'h1
`define FN_CONTROL 4'h2
`define FN_STATUS 4'h3
`define FN_MASK 4'h4
`define FN_PREADDR 4'h5
`define FN_PREADDR_OFF 4'h6

// Words moved per chained control set fetch
`define CW_COUNT 2'h3

// Pacing of DMA items: 700,000 words per second at 40 MHz
`define CLK_KHZ 40000
`define DMA_WORDS_PER_SEC 700000
`define DMA_ITEM_CYC ((`CLK_KHZ * 1000) / `DMA_WORDS_PER_SEC)

`endif

// file: logic/sync2.v
// Two flip-flop synchroniser for a group of pin levels.
// Assumes each bit is a level that stays put for several clocks.
`timescale 1ns/1ps

module sync2 #(
  parameter W = 1
) (
  input wire clk, // System clock
  input wire nrst, // Synchronous reset, active low
  input wire [W-1:0] d, // Asynchronous level inputs
  output reg [W-1:0] q // Synchronised levels
);

  reg [W-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (!nrst) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// file: bench/io_master_assertions.sv
// Port checker of the I/O master: strobes, priority chain, memory, pacing.
// Bound to every io_master instance; sees only its ports.
`timescale 1ns/1ps
`include "io_master_map.vh"

module io_master_chk (
  input wire clk, // System clock
  input wire nrst, // Reset, active low
  input wire ioi_valid, // Instruction strobe
  input wire [3:0] ioi_fn, // Instruction function
  input wire ioi_ack, // Instruction taken
  input wire user_rd, // Read strobe
  input wire user_ctl, // Control strobe
  input wire pri_in, // Chain in
  input wire pri_out, // Chain out
  input wire bp_irq, // Backplane request
  input wire mem_req, // Memory request
  input wire mem_gnt, // Memory done
  input wire [15:0] mem_addr, // Memory address
  input wire user_dack // Item taken
);
  localparam int GAP = `DMA_ITEM_CYC - 1;
  logic [6:0] gap_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Cycles since the last item; starts full so reset never blocks one
  always @(posedge clk) begin
    if (!nrst) gap_q <= 7'h7F;
    else if (user_dack) gap_q <= 7'h00;
    else if (gap_q != 7'h7F) gap_q <= gap_q + 7'h01;
  end

  AST_ACK_CAUSE:
    assert property (ioi_ack |-> $past(ioi_valid))
    else $error("ack with no instruction before it");
  AST_RD_STROBE:
    assert property (ioi_ack |-> user_rd == ($past(ioi_fn) == `FN_READ))
    else $error("read strobe does not follow function");
  AST_CTL_STROBE:
    assert property (user_ctl |-> ioi_ack && $past(ioi_fn) == `FN_CONTROL)
    else $error("control strobe without control instruction");
  AST_CHAIN_BLOCK:
    assert property (bp_irq |-> !pri_out)
    else $error("chain passed on while requesting");
  AST_CHAIN_FREE:
    assert property (!$past(pri_in) |-> !bp_irq && !pri_out)
    else $error("request or pass without chain grant");
  AST_MEM_HOLD:
    assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped or moved early");
  AST_MEM_DROP:
    assert property (mem_gnt && mem_req |=> !mem_req)
    else $error("memory request kept after grant");
  AST_PACE:
    assert property (user_dack |-> gap_q >= GAP)
    else $error("items closer than pacing allows");

  COV_DACK: cover property (user_dack);
  COV_GRANT: cover property (mem_gnt ##1 !mem_req);
  COV_BPIRQ: cover property (bp_irq ##1 !bp_irq);
endmodule

bind io_master io_master_chk u_chk (.*);

// file: bench/mem_model.sv
// Backplane memory partner answering the I/O master's memory cycles.
// Assumes one request at a time, held until granted.
`timescale 1ns/1ps

module mem_model (
  input wire clk, // System clock
  input wire nrst, // Reset, active low
  input wire mem_req, // Cycle request
  input wire mem_we, // Cycle is a write
  input wire [15:0] mem_addr, // Word address
  input wire [15:0] mem_wdata, // Write data
  input wire [3:0] slow, // Wait cycles before grant
  output reg mem_gnt, // Cycle done pulse
  output reg [15:0] mem_rdata // Read data, valid with grant
);
  reg [15:0] ram [0:255];
  reg [3:0] wait_q;

  // Grant after the chosen wait; data is scrambled off the grant cycle
  // so a stale word reads back inverted only on every other cycle
  always @(posedge clk) begin
    mem_gnt <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!nrst) begin
      wait_q <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_gnt) begin
      if (wait_q >= slow) begin
        mem_gnt <= 1'b1;
        wait_q <= 4'h0;
        if (mem_we)
          ram[mem_addr[7:0]] <= mem_wdata;
        else
          mem_rdata <= ram[mem_addr[7:0]];
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// file: bench/testbench.sv
// Self-checking bench of the I/O master: APB, instructions, interrupt
// chain and chained DMA. Assumes the map header and the memory model.
`timescale 1ns/1ps
`include "io_master_map.vh"

module testbench;
  logic clk, nrst, psel, penable, pwrite, ioi_valid, pri_in, err, hit;
  logic user_dreq, user_attn;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [5:0] sc_switch, ioi_sc, sw, tsc;
  logic [3:0] ioi_fn, slow, st, fn;
  logic [15:0] ioi_wdata, user_rdata, w0, w1, w2;
  wire [31:0] prdata;
  wire pready, pslverr, irq, ioi_ack, pri_out, bp_irq, mem_req, mem_we;
  wire mem_gnt, user_wr, user_rd, user_ctl, user_dack;
  wire [15:0] ioi_rdata, mem_addr, mem_wdata, mem_rdata, user_wdata;
  wire [5:0] user_addr;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  logic [15:0] outq[$];

  io_master DUT (.*);
  mem_model u_mem (.*);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end

  // Items handed to the user by DMA output carry no instruction ack
  always @(posedge clk) begin
    if (user_wr && !ioi_ack) outq.push_back(user_wdata);
  end

  function automatic logic [3:0] strobes(input logic h, input logic [3:0] f);
    strobes = h ? {1'b1, f == `FN_READ, f == `FN_WRITE, f == `FN_CONTROL}
                : 4'h0;
  endfunction

  function automatic logic [15:0] pack(input logic [7:0] lo, hi);
    pack = {hi, lo};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One backplane instruction; strobes sampled in the ack cycle
  task automatic ioi(input logic [5:0] sc, input logic [3:0] f);
    @(posedge clk);
    ioi_valid <= 1'b1;
    ioi_sc <= sc;
    ioi_fn <= f;
    ioi_wdata <= w0;
    @(posedge clk);
    ioi_valid <= 1'b0;
    @(posedge clk);
    st = {ioi_ack, user_rd, user_wr, user_ctl};
  endtask

  // One DMA item; long lead lets a chained fetch finish first
  task automatic item(input logic [15:0] d);
    int k;
    user_rdata <= d;
    repeat (24) @(posedge clk);
    user_dreq <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (user_dack !== 1'b1 && user_wr !== 1'b1 && k < 30);
    chk(k < 30, 1'b1);
    user_dreq <= 1'b0;
    repeat (64) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    sw = $urandom(32'h316d65f0);
    sw = 6'($urandom);
    {psel, penable, pwrite, ioi_valid, user_dreq, user_attn} = 6'h00;
    {paddr, pwdata, ioi_sc, ioi_fn, ioi_wdata} = '0;
    user_rdata = 16'($urandom);
    sc_switch = sw;
    pri_in = 1'b1;
    slow = 4'h0;
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h3C, 32'hFFFFFFFF);
    chk(err, 1'b1);
    apb(1'b0, 8'h3C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    // Functions hit and missed, then again while preaddressed
    for (int i = 0; i < 12; i++) begin
      if (i == 6) begin
        apb(1'b1, `REG_PREADDR, {26'h0, sw});
        apb(1'b1, `REG_CTRL, 32'h10);
      end
      tsc = i[0] ? sw : sw ^ 6'($urandom_range(63, 1));
      fn = 4'(i / 2 % 3);
      w0 = 16'($urandom);
      hit = i >= 6 || tsc == sw;
      ioi(tsc, fn);
      chk(st, strobes(hit, fn));
      if (hit) chk(user_addr, i >= 6 ? tsc : 6'h00);
      if (hit && fn == `FN_WRITE) chk(user_wdata, w0);
      if (hit && fn == `FN_READ) chk(ioi_rdata, user_rdata);
    end
    ioi(sw ^ 6'h15, `FN_PREADDR_OFF);
    ioi(sw ^ 6'h15, `FN_CONTROL);
    chk(st, 4'h0);
    w0 = {10'h0, sw};
    ioi(sw ^ 6'h15, `FN_PREADDR);
    ioi(sw ^ 6'h15, `FN_CONTROL);
    chk(st, 4'b1001);
    ioi(sw, `FN_PREADDR_OFF);
    // Interrupt raised, chained, masked and cleared
    apb(1'b1, `REG_IRQ_EN, 32'h7);
    user_attn <= 1'b1;
    for (int k = 0; k < 10 && irq !== 1'b1; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk({irq, bp_irq, pri_out}, 3'b110);
    pri_in <= 1'b0;
    repeat (2) @(posedge clk);
    chk({bp_irq, pri_out}, 2'b00);
    pri_in <= 1'b1;
    w0 = ~(16'h1 << sw[3:0]);
    ioi(sw, `FN_MASK);
    repeat (2) @(posedge clk);
    chk({bp_irq, pri_out}, 2'b10);
    apb(1'b1, `REG_MASK, 32'h1 << sw[3:0]);
    repeat (2) @(posedge clk);
    chk({bp_irq, pri_out}, 2'b01);
    ioi(sw, `FN_STATUS);
    chk(ioi_rdata[`IRQ_USER_ATTN], 1'b1);
    user_attn <= 1'b0;
    apb(1'b1, `REG_IRQ_CLR, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    // Word block input, one interrupt at the end only
    slow <= 4'h2;
    apb(1'b1, `REG_DMA_ADDR, 32'h40);
    apb(1'b1, `REG_DMA_COUNT, 32'h2);
    apb(1'b1, `REG_CTRL, 32'h1);
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    item(w0);
    chk(irq, 1'b0);
    item(w1);
    chk(irq, 1'b1);
    chk({u_mem.ram[8'h41], u_mem.ram[8'h40]}, {w1, w0});
    apb(1'b1, `REG_IRQ_CLR, 32'h7);
    // Byte input packs low byte first, odd last byte alone
    apb(1'b1, `REG_DMA_ADDR, 32'h50);
    apb(1'b1, `REG_DMA_COUNT, 32'h3);
    apb(1'b1, `REG_CTRL, 32'h5);
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    w2 = 16'($urandom);
    item(w0);
    item(w1);
    item(w2);
    chk(u_mem.ram[8'h50], pack(w0[7:0], w1[7:0]));
    chk(u_mem.ram[8'h51], pack(w2[7:0], 8'h00));
    apb(1'b1, `REG_IRQ_CLR, 32'h7);
    // Word output block: one memory word handed to the user whole
    u_mem.ram[8'h90] = w2;
    apb(1'b1, `REG_DMA_ADDR, 32'h90);
    apb(1'b1, `REG_DMA_COUNT, 32'h1);
    outq.delete();
    apb(1'b1, `REG_CTRL, 32'h9);
    item(16'h0000);
    chk(outq[0], w2);
    chk(irq, 1'b1);
    apb(1'b1, `REG_IRQ_CLR, 32'h7);
    // Two chained sets: word input, then byte output ending the chain
    u_mem.ram[8'h80] = 16'h0060;
    u_mem.ram[8'h81] = 16'h0001;
    u_mem.ram[8'h82] = 16'h0004;
    u_mem.ram[8'h83] = 16'h0070;
    u_mem.ram[8'h84] = 16'h0002;
    u_mem.ram[8'h85] = 16'h0003;
    u_mem.ram[8'h70] = w1;
    slow <= 4'h3;
    apb(1'b1, `REG_CHAIN_PTR, 32'h80);
    apb(1'b1, `REG_CTRL, 32'h3);
    item(w0);
    chk(irq, 1'b0);
    outq.delete();
    item(16'h0000);
    item(16'h0000);
    chk(u_mem.ram[8'h60], w0);
    chk({outq[1][7:0], outq[0][7:0]}, w1);
    chk(irq, 1'b1);
    apb(1'b0, `REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    final_report;
  end
endmodule
